// >>> hdl/pwu_osc_div.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Tick divider standing in for the private wakeup oscillator
// ----------------------------------------------------------------------
module pwu_osc_div #(
    parameter DIV = 100000
) (
    input  wire clk_in,
    input  wire rst_in,
    input  wire run_in,
    output reg  tick_out
);
    reg [31:0] cnt_reg;

    // The oscillator only runs while stopped, so it restarts in phase.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg  <= 32'h0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_reg  <= 32'h0;
            tick_out <= 1'b0;
        end else if (cnt_reg == DIV - 1) begin
            cnt_reg  <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule

// >>> hdl/pwu_top.v
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "pwu_map.vh"

// Functional notes
// - Periodic wakeup requests leave stop mode without any pin activity.
// - Request enters keypad interrupt logic as an internal source.
// - Software enable bit in keypad enable register gates wakeup input.
// - Request high with enable set sets the wakeup latch.
// - Wakeup latch reads back on bit 6 of port A data.
// - That bit is read-only; no direction or pullup bit exists.
// - Entering stop mode enables the wakeup generator.
// - Counter is clocked by its own private oscillator ticks.
// - Reaching the selected overflow count latches and forwards a request.
// - Serviced only with enable set, through the keypad vector; here status bit 1 still takes every request, and irq_out does when IRQ enable bit 1 is set.
// - Watchdog rate-select bit in config one picks the overflow count.
// - Rate-select 0 gives the long period, about 650 ms.
// - Rate-select 1 gives the short period, about 16 ms.
// - Keypad interrupt mask also masks the wakeup interrupt.
module pwu_top #(
    parameter TICK_CYCLES = `PWU_TICK_CYCLES,
    parameter LONG_TICKS  = `PWU_LONG_TICKS,
    parameter SHORT_TICKS = `PWU_SHORT_TICKS
) (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        stop_mode_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hsel_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    output reg         keypad_irq_out,
    output reg         wakeup_exit_out,
    output reg         irq_out
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg        wakeup_latch_reg;
    reg [7:0]  keypad_irq_enable_reg;
    reg [7:0]  config_register_one;
    reg [1:0]  irq_stat_reg;
    reg [1:0]  irq_en_reg;
    reg [19:0] wake_cnt_reg;
    reg        wakeup_request;
    reg        stop_q_reg;
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;
    wire       osc_tick;

    function is_reg;
        input [7:0] a;
        begin
            is_reg = (a == `PWU_OFS_PORTA) || (a == `PWU_OFS_KBIEN) ||
                     (a == `PWU_OFS_CFG1) || (a == `PWU_OFS_CTRL) ||
                     (a == `PWU_OFS_IRQ_STAT) || (a == `PWU_OFS_IRQ_EN) ||
                     (a == `PWU_OFS_IRQ_CLR);
        end
    endfunction

    wire wakeup_irq_enable = keypad_irq_enable_reg[`PWU_BIT_WKIE];
    wire keypad_mask       = keypad_irq_enable_reg[`PWU_BIT_KBMASK];
    wire rate_sel          = config_register_one[`PWU_BIT_RATESEL];
    wire [19:0] ovf_ticks  = rate_sel ? SHORT_TICKS[19:0] :
                                        LONG_TICKS[19:0];
    wire ovf_hit = osc_tick && (wake_cnt_reg == ovf_ticks - 20'h1);
    // Acknowledge acts in the write's data phase, so a read whose address phase
    // overlaps that data phase still sees the latch set; a later read sees it cleared.
    wire ack_now = wr_pend_reg && (wr_addr_reg == `PWU_OFS_KBIEN) &&
                   hwdata_in[`PWU_BIT_KBACK];

    // ------------------------------------------------------------------
    // Private oscillator
    // ------------------------------------------------------------------
    pwu_osc_div #(
        .DIV (TICK_CYCLES)
    ) u_osc (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .run_in   (stop_mode_in),
        .tick_out (osc_tick)
    );

    // ------------------------------------------------------------------
    // Wakeup generator
    // ------------------------------------------------------------------
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_cnt_reg   <= 20'h0;
            wakeup_request <= 1'b0;
            stop_q_reg     <= 1'b0;
        end else begin
            stop_q_reg     <= stop_mode_in;
            wakeup_request <= ovf_hit;
            if (!stop_mode_in || !stop_q_reg)
                wake_cnt_reg <= 20'h0;
            else if (ovf_hit)
                wake_cnt_reg <= 20'h0;
            else if (osc_tick)
                wake_cnt_reg <= wake_cnt_reg + 20'h1;
        end
    end

    // Set wins over acknowledge so a request in the clear cycle survives.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wakeup_latch_reg <= 1'b0;
        end else if (wakeup_request && wakeup_irq_enable) begin
            wakeup_latch_reg <= 1'b1;
        end else if (ack_now) begin
            wakeup_latch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    wire take = hsel_in && hready_in && htrans_in[1];
    wire wr_now = wr_pend_reg;
    wire [7:0] wd = hwdata_in[7:0];

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_reg           <= 1'b0;
            wr_addr_reg           <= 8'h00;
            hrdata_out            <= 32'h0;
            hreadyout_out         <= 1'b1;
            hresp_out             <= 1'b0;
            keypad_irq_enable_reg <= `PWU_RST_KBIEN;
            config_register_one   <= `PWU_RST_CFG1;
            irq_en_reg            <= `PWU_RST_IRQ_EN;
        end else begin
            wr_pend_reg   <= take && hwrite_in;
            wr_addr_reg   <= haddr_in[7:0];
            if (take && !hwrite_in) begin
                case (haddr_in[7:0])
                    `PWU_OFS_PORTA:    hrdata_out <= {25'h0,
                        wakeup_latch_reg, 6'h0};
                    `PWU_OFS_KBIEN:    hrdata_out <= {24'h0,
                        keypad_irq_enable_reg & 8'h42};
                    `PWU_OFS_CFG1:     hrdata_out <= {24'h0,
                        config_register_one};
                    `PWU_OFS_CTRL:     hrdata_out <= {31'h0, stop_mode_in};
                    `PWU_OFS_IRQ_STAT: hrdata_out <= {30'h0, irq_stat_reg};
                    `PWU_OFS_IRQ_EN:   hrdata_out <= {30'h0, irq_en_reg};
                    default:           hrdata_out <= 32'h0;
                endcase
            end
            // Port A data and unmapped offsets swallow writes silently.
            if (wr_now && is_reg(wr_addr_reg)) begin
                case (wr_addr_reg)
                    `PWU_OFS_KBIEN: begin
                        keypad_irq_enable_reg <= wd & 8'h42;
                    end
                    `PWU_OFS_CFG1:   config_register_one <= wd;
                    `PWU_OFS_IRQ_EN: irq_en_reg <= wd[1:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and outputs
    // ------------------------------------------------------------------
    wire [1:0] ev_set = {wakeup_request, wakeup_request && wakeup_irq_enable};
    wire [1:0] ev_clr = (wr_now && wr_addr_reg == `PWU_OFS_IRQ_CLR) ?
                        hwdata_in[1:0] : 2'h0;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_reg    <= 2'h0;
            irq_out         <= 1'b0;
            keypad_irq_out  <= 1'b0;
            wakeup_exit_out <= 1'b0;
        end else begin
            irq_stat_reg    <= (irq_stat_reg & ~ev_clr) | ev_set;
            irq_out         <= |(irq_stat_reg & irq_en_reg);
            keypad_irq_out  <= wakeup_latch_reg && wakeup_irq_enable &&
                               !keypad_mask;
            wakeup_exit_out <= wakeup_latch_reg && wakeup_irq_enable &&
                               !keypad_mask && stop_mode_in;
        end
    end
endmodule

// >>> shared/pwu_map.vh
`ifndef PWU_MAP_VH
`define PWU_MAP_VH

// Register byte offsets on the AHB-Lite slave.
`define PWU_OFS_PORTA     8'h00
`define PWU_OFS_KBIEN     8'h04
`define PWU_OFS_CFG1      8'h08
`define PWU_OFS_CTRL      8'h0c
`define PWU_OFS_IRQ_STAT  8'h10
`define PWU_OFS_IRQ_EN    8'h14
`define PWU_OFS_IRQ_CLR   8'h18

// Field positions.
`define PWU_BIT_LATCH     6
`define PWU_BIT_WKIE      6
`define PWU_BIT_KBMASK    1
`define PWU_BIT_KBACK     2
`define PWU_BIT_RATESEL   0
`define PWU_BIT_STOP      0
`define PWU_BIT_EV_WAKE   0
`define PWU_BIT_EV_REQ    1

// Reset values.
`define PWU_RST_KBIEN     8'h00
`define PWU_RST_CFG1      8'h00
`define PWU_RST_IRQ_EN    2'h0

// Wakeup periods in microseconds (5 V typical figures).
`define PWU_LONG_US       650000
`define PWU_SHORT_US      16000
// Dedicated oscillator tick period in microseconds.
`define PWU_TICK_US       1000
`define PWU_LONG_TICKS    (`PWU_LONG_US / `PWU_TICK_US)
`define PWU_SHORT_TICKS   (`PWU_SHORT_US / `PWU_TICK_US)
`define PWU_CLK_MHZ       100
`define PWU_TICK_CYCLES   (`PWU_TICK_US * `PWU_CLK_MHZ)

`endif

// >>> sim/pwu_core_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Processor side: sleeps on request, leaves stop on wakeup
// ------------------------------------------------------------
module pwu_core_model (
    input  logic clk_in,
    input  logic rst_in,
    input  logic run_stop_in,
    input  logic wake_in,
    output logic stop_out
);
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            stop_out <= 1'b0;
        else
            stop_out <= run_stop_in && !wake_in;
    end
endmodule

// >>> sim/pwu_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checks for the periodic wakeup unit
// ------------------------------------------------------------
module pwu_properties (
    input logic        clk_in,
    input logic        rst_in,
    input logic        stop_mode_in,
    input logic [31:0] haddr_in,
    input logic [1:0]  htrans_in,
    input logic        hwrite_in,
    input logic        hsel_in,
    input logic        hready_in,
    input logic [31:0] hrdata_out,
    input logic        hreadyout_out,
    input logic        hresp_out,
    input logic        keypad_irq_out,
    input logic        wakeup_exit_out,
    input logic        irq_out
);
    logic rd;
    assign rd = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    a_exit_in_stop: assert property (wakeup_exit_out |-> $past(stop_mode_in))
        else $error("wakeup exit outside stop");
    a_exit_with_irq: assert property (wakeup_exit_out |-> keypad_irq_out)
        else $error("wakeup exit without keypad request");
    a_exit_on_leave: assert property ($fell(stop_mode_in) |=> !wakeup_exit_out)
        else $error("wakeup exit held after stop");
    a_porta_only: assert property (rd && haddr_in == 32'h0 |=>
        (hrdata_out & 32'hffffffbf) == 32'h0) else $error("port A extra bits");
    a_latch_read: assert property (rd && haddr_in == 32'h0 && keypad_irq_out
        ##1 keypad_irq_out |-> hrdata_out[6])
        else $error("latch not read back");
    a_kirq_hold: assert property ($fell(keypad_irq_out) |-> $past(hwrite_in)
        || $past(hwrite_in, 2) || $past(hwrite_in, 3))
        else $error("keypad request dropped without a write");
    a_irq_hold: assert property ($fell(irq_out) |-> $past(hwrite_in)
        || $past(hwrite_in, 2)) else $error("interrupt dropped without a write");
    cover property ($rose(wakeup_exit_out));
    cover property ($fell(keypad_irq_out));
    cover property ($rose(irq_out));
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Register and wakeup period tests
// ------------------------------------------------------------
module tb_top;
    localparam TK = 4;
    localparam SH = 3;
    localparam LG = 6;
    logic        clk_in, rst_in, stop, go, hwrite, hsel, rdy, kirq, wexit, irq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    int          mismatches, samples_checked, n;
    pwu_top #(.TICK_CYCLES(TK), .LONG_TICKS(LG), .SHORT_TICKS(SH)) pwu_top_i (
        .clk_in(clk_in), .rst_in(rst_in), .stop_mode_in(stop),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hsel_in(hsel),
        .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy),
        .hresp_out(), .keypad_irq_out(kirq), .wakeup_exit_out(wexit),
        .irq_out(irq));
    pwu_core_model pwu_core_model_i (.clk_in(clk_in), .rst_in(rst_in),
        .run_stop_in(go), .wake_in(wexit), .stop_out(stop));
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge clk_in); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_in); while (rdy !== 1'b1);
        q = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // The count runs from the stop request, so it includes the entry edge.
    task nap;
        n = 0;
        go <= 1'b1;
        do begin @(posedge clk_in); n++; end while (wexit !== 1'b1 && n < 300);
        go <= 1'b0;
        @(posedge clk_in);
    endtask
    function logic [31:0] inr(input int lo);
        return {31'h0, n >= lo && n <= lo + 2 * TK + 4};
    endfunction
    task results;
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        rst_in = 1'b1;
        {go, hwrite, hsel, haddr, hwdata, htrans} = 69'h0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        bus(1'b1, 8'h00, 32'hffffffff);
        rd(8'h00, 32'h0);
        rd(8'h1c, 32'h0);
        nap;
        chk(n, 300);
        rd(8'h00, 32'h0);
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h04, 32'h40);
        bus(1'b1, 8'h08, 32'h1);
        nap;
        chk(inr(SH * TK), 32'h1);
        chk(stop, 1'b0);
        chk(kirq, 1'b1);
        rd(8'h00, 32'h40);
        chk(irq, 1'b1);
        rd(8'h10, 32'h3);
        bus(1'b1, 8'h04, 32'h42);
        rd(8'h00, 32'h40);
        chk(kirq, 1'b0);
        bus(1'b1, 8'h04, 32'h44);
        rd(8'h00, 32'h0);
        bus(1'b1, 8'h18, 32'h3);
        rd(8'h10, 32'h0);
        chk(irq, 1'b0);
        bus(1'b1, 8'h08, 32'h0);
        nap;
        chk(inr(LG * TK), 32'h1);
        rd(8'h0c, 32'h0);
        results;
    end
endmodule
bind pwu_top pwu_properties pwu_properties_i (.clk_in(clk_in),
    .rst_in(rst_in), .stop_mode_in(stop_mode_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsel_in(hsel_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .keypad_irq_out(keypad_irq_out), .wakeup_exit_out(wakeup_exit_out),
    .irq_out(irq_out));
